/* oled_drive_analog_ctrl_map.svh */
// Offsets, field positions, reset values and timing of the analog drive bank.
// Notes on behaviour
// RL1: Ramp control bit 4 picks DAC resolution: 0 ten-bit, 1 nine-bit.
// RL2: Ramp control bit 3 set forces the ramp DAC to all-high for test.
// RL3: Ramp control bit 2 picks retrace time: 0 gives 500 ns, 1 gives 800 ns.
// RL4: Ramp start shift bits 1-0: 00 half pixel clock early, 01 none, 10 late.
// RL5: Software leaves ramp control bits 7-5 at zero.
// RL6: Buffer bias bits 6-4: 000 off, 25% steps, 100 nominal, reset 011.
// RL7: Ramp bias bit 3 enables ramp buffer output monitoring; off at reset.
// RL8: Amplifier bias bits 2-0 use the same encoding; reset 010.
// RL9: Ramp DAC ceiling is eight bits, resets to 80h, scales maximum by 40%.
// RL10: Software programs the ramp DAC ceiling to 74h for normal use.
// RL11: Pixel bias bit 3 picks external reference; keep internal, the reset.
// RL12: Pixel sink current bits 2-0: 000 off, 111 maximum, reset 1, advise 4.
// RL13: Gamma bit 4 holds the cathode converter switch while gamma sampling.
// RL14: Gamma bit 3 enables sense pin sample-and-hold; bypassed at reset.
// RL15: Gamma current step code n gives reference current over 2 to 7-n.
// RL16: Host waits 10 ms after a step change and samples during blanking.
// RL17: Current sense bits 3-2: 00 off, 01 or 10 on, 11 unused.
// RL18: Cathode mode bits 1-0: 00 current, 01 clamped, 10 manual regulation.
// RL19: Current regulation follows the internal current loop request.
// RL20: Clamped regulation follows the loop but clamps at the level setting.
// RL21: Manual mode holds the cathode level setting as a fixed voltage.
// RL22: Level setting drives the output in modes 01 and 10, uncompensated.
// RL23: Each register reads back what was written to its implemented bits, others as zero, and resets to defaults.
`ifndef OLED_DRIVE_ANALOG_CTRL_MAP_SVH
`define OLED_DRIVE_ANALOG_CTRL_MAP_SVH
`define RAMP_CONTROL_OFFSET 8'h0b
`define RAMP_BIAS_CONTROL_OFFSET 8'h0c
`define RAMP_DAC_CEILING_OFFSET 8'h0d
`define PIXEL_BIAS_CONTROL_OFFSET 8'h0e
`define GAMMA_SENSOR_CONTROL_OFFSET 8'h0f
`define CATHODE_SUPPLY_MODE_CONTROL_OFFSET 8'h10
`define RAMP_CONTROL_RESET 8'h01
`define RAMP_BIAS_CONTROL_RESET 8'h32
`define RAMP_DAC_CEILING_RESET 8'h80
`define PIXEL_BIAS_CONTROL_RESET 8'h01
`define GAMMA_SENSOR_CONTROL_RESET 8'h00
`define CATHODE_SUPPLY_MODE_CONTROL_RESET 8'h00
`define RAMP_CONTROL_MASK 8'hff
`define RAMP_BIAS_CONTROL_MASK 8'h7f
`define RAMP_DAC_CEILING_MASK 8'hff
`define PIXEL_BIAS_CONTROL_MASK 8'h0f
`define GAMMA_SENSOR_CONTROL_MASK 8'h1f
`define CATHODE_SUPPLY_MODE_CONTROL_MASK 8'h0f
`define RAMP_DAC_RES_SEL_BIT 4
`define RAMP_DAC_FORCE_HIGH_BIT 3
`define RETRACE_DURATION_SEL_BIT 2
`define RAMP_START_SHIFT_MSB 1
`define RAMP_START_SHIFT_LSB 0
`define RAMP_BUFFER_BIAS_MSB 6
`define RAMP_BUFFER_BIAS_LSB 4
`define RAMP_BUFFER_MONITOR_EN_BIT 3
`define RAMP_AMP_BIAS_MSB 2
`define RAMP_AMP_BIAS_LSB 0
`define EXTERNAL_REFERENCE_SEL_BIT 3
`define PIXEL_SINK_CURRENT_MSB 2
`define PIXEL_SINK_CURRENT_LSB 0
`define CONVERTER_PUMP_HOLD_EN_BIT 4
`define GAMMA_SENSE_SAMPLE_HOLD_EN_BIT 3
`define GAMMA_SENSE_CURRENT_STEP_MSB 2
`define GAMMA_SENSE_CURRENT_STEP_LSB 0
`define CONVERTER_CURRENT_SENSE_EN_MSB 3
`define CONVERTER_CURRENT_SENSE_EN_LSB 2
`define CATHODE_SUPPLY_MODE_MSB 1
`define CATHODE_SUPPLY_MODE_LSB 0
`define SYS_CLK_PERIOD_NS 100
`define RETRACE_SHORT_NS 500
`define RETRACE_LONG_NS 800
`define GAMMA_SETTLE_MS 10
`endif

/* oled_drive_analog_ctrl_pkg.sv */
// Types shared by the analog drive configuration bank.
package oled_drive_analog_ctrl_pkg;
   typedef enum logic [1:0] {
      current_regulation_mode,
      clamped_regulation_mode,
      manual_mode,
      unused_mode
   } cathode_mode_type;
   typedef enum logic {
      retrace_idle,
      retrace_run
   } retrace_state_type;
endpackage : oled_drive_analog_ctrl_pkg

/* oled_drive_analog_ctrl_regs.sv */
// Analog drive configuration registers with their decoded control outputs.
`timescale 1ns/1ns
`include "oled_drive_analog_ctrl_map.svh"
module oled_drive_analog_ctrl_regs
   import oled_drive_analog_ctrl_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES =
      `GAMMA_SETTLE_MS * 1000000 / `SYS_CLK_PERIOD_NS
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic nrst,
   // Register access from the serial configuration port.
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   output logic [7:0] cfg_rdata,
   output logic cfg_rd_valid,
   output logic cfg_hit,
   // Ramp DAC controls.
   output logic ramp_dac_res_sel,
   output logic ramp_dac_force_high,
   output logic retrace_duration_sel,
   output logic [1:0] ramp_start_shift,
   output logic [7:0] ramp_dac_max_level,
   // Ramp retrace timing.
   input wire logic ramp_retrace_start,
   output logic ramp_retrace_active,
   // Ramp bias currents.
   output logic [2:0] ramp_buffer_bias,
   output logic ramp_buffer_powered,
   output logic ramp_buffer_monitor_en,
   output logic [2:0] ramp_amp_bias,
   output logic ramp_amp_powered,
   // Pixel bias.
   output logic external_reference_sel,
   output logic [2:0] pixel_sink_current,
   output logic pixel_sink_on,
   // Gamma sensor.
   input wire logic gamma_sample_window,
   output logic converter_switch_hold,
   output logic gamma_sense_sample_hold_en,
   output logic [2:0] gamma_sense_current_step,
   output logic [2:0] gamma_sense_divide_log2,
   output logic gamma_sense_settling,
   // Cathode supply converter.
   input wire logic [7:0] cathode_level_setting,
   input wire logic [7:0] regulation_level_request,
   output cathode_mode_type cathode_supply_mode,
   output logic converter_current_sense_on,
   output logic dimming_in_use,
   output logic [7:0] cathode_drive_level,
   output logic cathode_clamp_active
);

   localparam int NUM_REGS = 6;
   localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
   localparam int unsigned RETRACE_SHORT_CYCLES =
      (`RETRACE_SHORT_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS;
   localparam int unsigned RETRACE_LONG_CYCLES =
      (`RETRACE_LONG_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS;

   localparam logic [7:0] offset_table [NUM_REGS] = '{
      `RAMP_CONTROL_OFFSET,
      `RAMP_BIAS_CONTROL_OFFSET,
      `RAMP_DAC_CEILING_OFFSET,
      `PIXEL_BIAS_CONTROL_OFFSET,
      `GAMMA_SENSOR_CONTROL_OFFSET,
      `CATHODE_SUPPLY_MODE_CONTROL_OFFSET
   };
   localparam logic [7:0] reset_table [NUM_REGS] = '{
      `RAMP_CONTROL_RESET,
      `RAMP_BIAS_CONTROL_RESET,
      `RAMP_DAC_CEILING_RESET,
      `PIXEL_BIAS_CONTROL_RESET,
      `GAMMA_SENSOR_CONTROL_RESET,
      `CATHODE_SUPPLY_MODE_CONTROL_RESET
   };
   localparam logic [7:0] mask_table [NUM_REGS] = '{
      `RAMP_CONTROL_MASK,
      `RAMP_BIAS_CONTROL_MASK,
      `RAMP_DAC_CEILING_MASK,
      `PIXEL_BIAS_CONTROL_MASK,
      `GAMMA_SENSOR_CONTROL_MASK,
      `CATHODE_SUPPLY_MODE_CONTROL_MASK
   };

   localparam int IDX_RAMP = 0;
   localparam int IDX_BIAS = 1;
   localparam int IDX_CEIL = 2;
   localparam int IDX_PIXEL = 3;
   localparam int IDX_GAMMA = 4;
   localparam int IDX_CATHODE = 5;

   logic [7:0] reg_file [NUM_REGS];
   logic [NUM_REGS-1:0] reg_sel;
   logic [7:0] read_terms [NUM_REGS];
   logic [7:0] read_value;
   logic addr_hit;

   // Address decode and storage, one entry per register.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
         assign reg_sel[gi] = (cfg_addr == offset_table[gi]);
         assign read_terms[gi] = reg_sel[gi] ? reg_file[gi] : 8'h00;
         // Unimplemented bits are masked so they always read as zero.
         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               reg_file[gi] <= reset_table[gi]; // see RL23
            end else if (cfg_wr && reg_sel[gi]) begin
               reg_file[gi] <= cfg_wdata & mask_table[gi]; // see RL23
            end
         end
      end
   endgenerate

   assign addr_hit = |reg_sel;

   always_comb begin
      read_value = 8'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
         read_value = read_value | read_terms[i]; // see RL23
      end
   end

   // A read taken with a write in the same cycle returns the old value.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cfg_rdata <= 8'h00;
         cfg_rd_valid <= 1'b0;
         cfg_hit <= 1'b0;
      end else begin
         cfg_rdata <= cfg_rd ? read_value : cfg_rdata;
         cfg_rd_valid <= cfg_rd;
         cfg_hit <= (cfg_rd | cfg_wr) & addr_hit;
      end
   end

   // Field views of the stored registers.
   wire res_field = reg_file[IDX_RAMP][`RAMP_DAC_RES_SEL_BIT];
   wire force_field = reg_file[IDX_RAMP][`RAMP_DAC_FORCE_HIGH_BIT];
   wire retrace_field = reg_file[IDX_RAMP][`RETRACE_DURATION_SEL_BIT];
   wire [1:0] shift_field =
      reg_file[IDX_RAMP][`RAMP_START_SHIFT_MSB:`RAMP_START_SHIFT_LSB];
   wire [2:0] buf_field =
      reg_file[IDX_BIAS][`RAMP_BUFFER_BIAS_MSB:`RAMP_BUFFER_BIAS_LSB];
   wire mon_field = reg_file[IDX_BIAS][`RAMP_BUFFER_MONITOR_EN_BIT];
   wire [2:0] amp_field =
      reg_file[IDX_BIAS][`RAMP_AMP_BIAS_MSB:`RAMP_AMP_BIAS_LSB];
   wire ext_field = reg_file[IDX_PIXEL][`EXTERNAL_REFERENCE_SEL_BIT];
   wire [2:0] sink_field =
      reg_file[IDX_PIXEL][`PIXEL_SINK_CURRENT_MSB:`PIXEL_SINK_CURRENT_LSB];
   wire pump_field = reg_file[IDX_GAMMA][`CONVERTER_PUMP_HOLD_EN_BIT];
   wire sh_field = reg_file[IDX_GAMMA][`GAMMA_SENSE_SAMPLE_HOLD_EN_BIT];
   wire [2:0] step_field = reg_file[IDX_GAMMA]
      [`GAMMA_SENSE_CURRENT_STEP_MSB:`GAMMA_SENSE_CURRENT_STEP_LSB];
   wire [1:0] sense_field = reg_file[IDX_CATHODE]
      [`CONVERTER_CURRENT_SENSE_EN_MSB:`CONVERTER_CURRENT_SENSE_EN_LSB];
   wire [1:0] mode_field = reg_file[IDX_CATHODE]
      [`CATHODE_SUPPLY_MODE_MSB:`CATHODE_SUPPLY_MODE_LSB];

   // Decoded terms for the analog side.
   wire [2:0] next_divide_log2 = 3'h7 - step_field; // see RL15
   wire next_pump_hold = pump_field & gamma_sample_window; // see RL13
   wire next_sense_on = (sense_field == 2'b01) |
                        (sense_field == 2'b10); // see RL17
   wire [7:0] gamma_next_data = cfg_wdata & `GAMMA_SENSOR_CONTROL_MASK;
   wire step_written = cfg_wr & reg_sel[IDX_GAMMA];
   wire step_changed = step_written &
      (gamma_next_data[`GAMMA_SENSE_CURRENT_STEP_MSB:
                       `GAMMA_SENSE_CURRENT_STEP_LSB] != step_field);

   // Code 11 has no defined mode; it falls back to current regulation,
   // the reset mode, so a stray write cannot leave the converter unmanaged.
   cathode_mode_type next_mode;
   assign next_mode =
      (mode_field == 2'b01) ? clamped_regulation_mode :
      (mode_field == 2'b10) ? manual_mode :
      current_regulation_mode; // see RL18

   wire request_above = regulation_level_request > cathode_level_setting;
   wire next_clamp = (next_mode == clamped_regulation_mode) &
                     request_above; // see RL20
   wire [7:0] next_level =
      (next_mode == manual_mode) ? cathode_level_setting : // see RL21
      next_clamp ? cathode_level_setting : // see RL22
      regulation_level_request; // see RL19

   // Control outputs, all registered.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ramp_dac_res_sel <= 1'b0;
         ramp_dac_force_high <= 1'b0;
         retrace_duration_sel <= 1'b0;
         ramp_start_shift <= 2'h1;
         ramp_dac_max_level <= `RAMP_DAC_CEILING_RESET;
      end else begin
         ramp_dac_res_sel <= res_field; // see RL1
         ramp_dac_force_high <= force_field; // see RL2
         retrace_duration_sel <= retrace_field; // see RL3
         ramp_start_shift <= shift_field; // see RL4
         ramp_dac_max_level <= reg_file[IDX_CEIL]; // see RL9
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ramp_buffer_bias <= 3'h3;
         ramp_buffer_powered <= 1'b1;
         ramp_buffer_monitor_en <= 1'b0;
         ramp_amp_bias <= 3'h2;
         ramp_amp_powered <= 1'b1;
      end else begin
         ramp_buffer_bias <= buf_field; // see RL6
         ramp_buffer_powered <= (buf_field != 3'h0); // see RL6
         ramp_buffer_monitor_en <= mon_field; // see RL7
         ramp_amp_bias <= amp_field; // see RL8
         ramp_amp_powered <= (amp_field != 3'h0); // see RL8
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         external_reference_sel <= 1'b0;
         pixel_sink_current <= 3'h1;
         pixel_sink_on <= 1'b1;
      end else begin
         external_reference_sel <= ext_field; // see RL11
         pixel_sink_current <= sink_field; // see RL12
         pixel_sink_on <= (sink_field != 3'h0); // see RL12
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         converter_switch_hold <= 1'b0;
         gamma_sense_sample_hold_en <= 1'b0;
         gamma_sense_current_step <= 3'h0;
         gamma_sense_divide_log2 <= 3'h7;
      end else begin
         converter_switch_hold <= next_pump_hold; // see RL13
         gamma_sense_sample_hold_en <= sh_field; // see RL14
         gamma_sense_current_step <= step_field; // see RL15
         gamma_sense_divide_log2 <= next_divide_log2; // see RL15
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cathode_supply_mode <= current_regulation_mode;
         converter_current_sense_on <= 1'b0;
         dimming_in_use <= 1'b1;
         cathode_drive_level <= 8'h00;
         cathode_clamp_active <= 1'b0;
      end else begin
         cathode_supply_mode <= next_mode; // see RL18
         converter_current_sense_on <= next_sense_on; // see RL17
         dimming_in_use <= (next_mode == current_regulation_mode); // see RL19
         cathode_drive_level <= next_level; // see RL20
         cathode_clamp_active <= next_clamp; // see RL20
      end
   end

   // Settling guard for the gamma sense output. It only flags the wait the
   // host owes after a step change; the host still picks the blanking time.
   logic [SETTLE_W-1:0] settle_count;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         settle_count <= '0;
         gamma_sense_settling <= 1'b0;
      end else if (step_changed) begin
         settle_count <= SETTLE_W'(SETTLE_CYCLES - 1); // see RL16
         gamma_sense_settling <= 1'b1;
      end else if (settle_count != '0) begin
         settle_count <= settle_count - 1'b1;
         gamma_sense_settling <= 1'b1;
      end else begin
         gamma_sense_settling <= 1'b0;
      end
   end

   // Retrace window timer. The length is latched at the start so that a
   // register write during a retrace cannot stretch or cut it short.
   retrace_state_type retrace_state;
   retrace_state_type next_retrace_state;
   logic [3:0] retrace_count;
   logic [3:0] next_retrace_count;
   wire [3:0] retrace_length = retrace_field ?
      4'(RETRACE_LONG_CYCLES) : 4'(RETRACE_SHORT_CYCLES); // see RL3

   always_comb begin
      next_retrace_state = retrace_state;
      next_retrace_count = retrace_count;
      unique case (retrace_state)
         retrace_idle: begin
            if (ramp_retrace_start) begin
               next_retrace_state = retrace_run;
               next_retrace_count = retrace_length - 4'h1;
            end
         end
         retrace_run: begin
            if (retrace_count == 4'h0) begin
               next_retrace_state = retrace_idle;
            end else begin
               next_retrace_count = retrace_count - 4'h1;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         retrace_state <= retrace_idle;
         retrace_count <= 4'h0;
         ramp_retrace_active <= 1'b0;
      end else begin
         retrace_state <= next_retrace_state;
         retrace_count <= next_retrace_count;
         ramp_retrace_active <= (next_retrace_state == retrace_run);
      end
   end

endmodule : oled_drive_analog_ctrl_regs

/* oled_drive_analog_ctrl_regs_checker.sv */
// Port checker for the analog drive register bank, bound to the design.
`timescale 1ns/1ns
module oled_drive_analog_ctrl_regs_checker
   import oled_drive_analog_ctrl_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = 20
) (
   // Clock and reset.
   input logic sys_clk,
   input logic nrst,
   // Register access.
   input logic [7:0] cfg_addr,
   input logic [7:0] cfg_wdata,
   input logic cfg_wr,
   input logic cfg_rd,
   input logic [7:0] cfg_rdata,
   input logic cfg_rd_valid,
   input logic cfg_hit,
   // Ramp.
   input logic ramp_dac_res_sel,
   input logic ramp_dac_force_high,
   input logic retrace_duration_sel,
   input logic [1:0] ramp_start_shift,
   input logic [7:0] ramp_dac_max_level,
   input logic ramp_retrace_start,
   input logic ramp_retrace_active,
   input logic [2:0] ramp_buffer_bias,
   input logic ramp_buffer_monitor_en,
   input logic [2:0] ramp_amp_bias,
   // Pixel bias and gamma sensor.
   input logic external_reference_sel,
   input logic [2:0] pixel_sink_current,
   input logic gamma_sample_window,
   input logic converter_switch_hold,
   input logic gamma_sense_sample_hold_en,
   input logic [2:0] gamma_sense_current_step,
   input logic [2:0] gamma_sense_divide_log2,
   input logic gamma_sense_settling,
   // Cathode supply.
   input logic [7:0] cathode_level_setting,
   input logic [7:0] regulation_level_request,
   input cathode_mode_type cathode_supply_mode,
   input logic converter_current_sense_on,
   input logic [7:0] cathode_drive_level,
   input logic cathode_clamp_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire [7:0] wa = cfg_wr ? cfg_addr : 8'h00;
   wire [7:0] req = regulation_level_request;
   wire [7:0] lvl = cathode_level_setting;
   wire mapped = cfg_addr >= 8'h0b && cfg_addr <= 8'h10;
   int unsigned run_len;
   always_ff @(posedge sys_clk) begin
      if (!nrst || !gamma_sense_settling) run_len <= 0;
      else run_len <= run_len + 1;
   end
   AST_RAMP_CTRL: assert property (
      wa == 8'h0b |-> ##2 {ramp_dac_res_sel, ramp_dac_force_high,
      retrace_duration_sel, ramp_start_shift} == $past(cfg_wdata[4:0], 2))
      else $error("ramp control outputs wrong");
   AST_RAMP_BIAS: assert property (
      wa == 8'h0c |-> ##2 {ramp_buffer_bias, ramp_buffer_monitor_en,
      ramp_amp_bias} == $past(cfg_wdata[6:0], 2))
      else $error("ramp bias outputs wrong");
   AST_CEILING: assert property (
      wa == 8'h0d |-> ##2 ramp_dac_max_level == $past(cfg_wdata, 2))
      else $error("ramp ceiling output wrong");
   AST_PIXEL: assert property (
      wa == 8'h0e |-> ##2 {external_reference_sel, pixel_sink_current}
      == $past(cfg_wdata[3:0], 2)) else $error("pixel bias outputs wrong");
   AST_GAMMA: assert property (
      wa == 8'h0f |-> ##2 {gamma_sense_sample_hold_en,
      gamma_sense_current_step} == $past(cfg_wdata[3:0], 2) &&
      gamma_sense_divide_log2 == 3'd7 - $past(cfg_wdata[2:0], 2))
      else $error("gamma sensor outputs wrong");
   AST_MODE: assert property (
      wa == 8'h10 && cfg_wdata[1:0] != 2'b11 |-> ##2 cathode_supply_mode
      == $past(cfg_wdata[1:0], 2) && converter_current_sense_on ==
      ^$past(cfg_wdata[3:2], 2)) else $error("cathode mode outputs wrong");
   AST_PUMP_HOLD: assert property (
      !gamma_sample_window |=> !converter_switch_hold)
      else $error("converter hold outside sampling");
   AST_CURRENT: assert property (
      $past(nrst) && cathode_supply_mode == current_regulation_mode |->
      cathode_drive_level == $past(req) && !cathode_clamp_active)
      else $error("current regulation level wrong");
   AST_CLAMP: assert property (
      $past(nrst) && cathode_supply_mode == clamped_regulation_mode |->
      cathode_clamp_active == ($past(req) > $past(lvl)) &&
      cathode_drive_level == ($past(req) > $past(lvl) ? $past(lvl) :
      $past(req))) else $error("clamped regulation level wrong");
   AST_MANUAL: assert property (
      $past(nrst) && cathode_supply_mode == manual_mode |->
      cathode_drive_level == $past(lvl)) else $error("manual level wrong");
   AST_UNMAPPED: assert property (
      cfg_rd && !mapped |=> cfg_rd_valid && cfg_rdata == 8'h00 && !cfg_hit)
      else $error("unmapped read answered");
   AST_RETRACE_SHORT: assert property (
      ramp_retrace_start && !ramp_retrace_active && !retrace_duration_sel
      |=> ramp_retrace_active [*5] ##1 !ramp_retrace_active)
      else $error("short retrace length wrong");
   AST_RETRACE_LONG: assert property (
      ramp_retrace_start && !ramp_retrace_active && retrace_duration_sel
      |=> ramp_retrace_active [*8] ##1 !ramp_retrace_active)
      else $error("long retrace length wrong");
   AST_SETTLE: assert property (
      $fell(gamma_sense_settling) |-> run_len == SETTLE_CYCLES)
      else $error("settle window length wrong");
   COV_CLAMP: cover property (cathode_clamp_active);
   COV_LONG: cover property (ramp_retrace_active && retrace_duration_sel);
   COV_SETTLE: cover property ($fell(gamma_sense_settling));
endmodule : oled_drive_analog_ctrl_regs_checker

bind oled_drive_analog_ctrl_regs oled_drive_analog_ctrl_regs_checker
   #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_checker (.*);

/* cfg_host_model.sv */
// Host side of the serial configuration port, as register write and read.
`timescale 1ns/1ns
module cfg_host_model (
   // Clock.
   input logic sys_clk,
   // Requests.
   output logic [7:0] cfg_addr,
   output logic [7:0] cfg_wdata,
   output logic cfg_wr,
   output logic cfg_rd,
   // Answers.
   input logic [7:0] cfg_rdata,
   input logic cfg_rd_valid
);
   initial begin
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
   end
   // Released lines are inverted so a stale value is never mistaken for data.
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      cfg_addr <= a;
      cfg_wdata <= (a == 8'h0b) ? {3'b000, d[4:0]} : d;
      cfg_wr <= 1'b1;
      @(posedge sys_clk);
      cfg_wr <= 1'b0;
      cfg_addr <= ~a;
      cfg_wdata <= ~d;
   endtask : put
   task automatic get(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
      @(posedge sys_clk);
      cfg_addr <= a;
      cfg_rd <= 1'b1;
      @(posedge sys_clk);
      cfg_rd <= 1'b0;
      cfg_addr <= ~a;
      #1;
      ok = cfg_rd_valid === 1'b1;
      d = cfg_rdata;
   endtask : get
endmodule : cfg_host_model

/* oled_drive_analog_ctrl_regs_tb.sv */
// Self-checking bench for the analog drive register bank.
`timescale 1ns/1ns
module oled_drive_analog_ctrl_regs_tb
   import oled_drive_analog_ctrl_pkg::*;
;
   localparam int unsigned SETTLE = 20;
   logic sys_clk, nrst, cfg_wr, cfg_rd, cfg_rd_valid, cfg_hit, ok;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, rv, ed, lvl, req, drv;
   logic res_sel, force_high, retr_sel, mon_en, buf_on, amp_on, ext_ref;
   logic sink_on, start, active, window, sw_hold, sh_en, settling;
   logic sense_on, dim_on, clamp;
   logic [1:0] shift, m;
   logic [2:0] buf_bias, amp_bias, sink, step, div_log2;
   logic [7:0] ceiling;
   cathode_mode_type mode;
   int num_errors = 0;
   int checks = 0;
   int n;
   logic [7:0] rst_val [6] = '{8'h01, 8'h32, 8'h80, 8'h01, 8'h00, 8'h00};
   logic [7:0] mask [6] = '{8'hff, 8'h7f, 8'hff, 8'h0f, 8'h1f, 8'h0f};
   logic [7:0] pat [6] = '{8'h1a, 8'h4b, 8'h74, 8'h84, 8'h1d, 8'h06};
   logic [7:0] bad [4] = '{8'h00, 8'h0a, 8'h11, 8'hff};

   cfg_host_model i_cfg_host_model (.sys_clk, .cfg_addr, .cfg_wdata,
      .cfg_wr, .cfg_rd, .cfg_rdata, .cfg_rd_valid);
   oled_drive_analog_ctrl_regs #(.SETTLE_CYCLES(SETTLE))
      i_oled_drive_analog_ctrl_regs (.sys_clk, .nrst, .cfg_addr, .cfg_wdata,
      .cfg_wr, .cfg_rd, .cfg_rdata, .cfg_rd_valid, .cfg_hit,
      .ramp_dac_res_sel(res_sel), .ramp_dac_force_high(force_high),
      .retrace_duration_sel(retr_sel), .ramp_start_shift(shift),
      .ramp_dac_max_level(ceiling), .ramp_retrace_start(start),
      .ramp_retrace_active(active), .ramp_buffer_bias(buf_bias),
      .ramp_buffer_powered(buf_on), .ramp_buffer_monitor_en(mon_en),
      .ramp_amp_bias(amp_bias), .ramp_amp_powered(amp_on),
      .external_reference_sel(ext_ref), .pixel_sink_current(sink),
      .pixel_sink_on(sink_on), .gamma_sample_window(window),
      .converter_switch_hold(sw_hold), .gamma_sense_sample_hold_en(sh_en),
      .gamma_sense_current_step(step), .gamma_sense_divide_log2(div_log2),
      .gamma_sense_settling(settling), .cathode_level_setting(lvl),
      .regulation_level_request(req), .cathode_supply_mode(mode),
      .converter_current_sense_on(sense_on), .dimming_in_use(dim_on),
      .cathode_drive_level(drv), .cathode_clamp_active(clamp));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_cfg_host_model.get(a, rv, ok);
      chk({6'h00, ok, cfg_hit}, {7'h01, a - 8'h0b < 8'h06});
      chk(rv, exp);
   endtask : rd_chk
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : tick
   // Counts settling cycles over a fixed span, the host's wait before sampling.
   task automatic settle_wait();
      n = 0;
      for (int i = 0; i < 40; i++) begin
         #1;
         n += (settling === 1'b1);
         @(posedge sys_clk);
      end
   endtask : settle_wait
   task automatic wrap_up();
      if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      #1ms;
      num_errors++;
      wrap_up();
   end

   initial begin
      nrst = 1'b0;
      start = 1'b0;
      window = 1'b0;
      lvl = 8'h51;
      req = 8'h60;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int a = 0; a < 6; a++) rd_chk(8'h0b + a, rst_val[a]);
      chk({res_sel, force_high, retr_sel, shift}, 8'h01);
      chk({buf_bias, mon_en, amp_bias}, 8'h32);
      chk(ceiling, 8'h80);
      chk({buf_on, amp_on, sink_on, dim_on, mode}, 8'h3c);
      chk({ext_ref, sink, div_log2}, 8'h0f);
      foreach (bad[b]) rd_chk(bad[b], 8'h00);
      i_cfg_host_model.put(8'h11, 8'hff);
      rd_chk(8'h10, 8'h00);
      // Writes one every other cycle, then reads one every other cycle, of every register.
      for (int a = 0; a < 6; a++) i_cfg_host_model.put(8'h0b + a, pat[a]);
      for (int a = 0; a < 6; a++)
         rd_chk(8'h0b + a, pat[a] & mask[a]);
      tick(1);
      chk({ext_ref, sink, buf_on, amp_on}, 8'h13);
      chk(ceiling, 8'h74);
      i_cfg_host_model.put(8'h0e, 8'h04);
      for (int k = 0; k < 4; k++) begin
         i_cfg_host_model.put(8'h10, {4'h0, k[1:0], k[1:0]});
         tick(1);
         m = (k == 3) ? 2'd0 : k[1:0];
         ed = (m == 2'd0) ? req : lvl;
         chk({clamp, sense_on, dim_on, 3'h0, mode},
             {m == 2'd1, k == 1 || k == 2, m == 2'd0, 3'h0, m});
         chk(drv, ed);
      end
      i_cfg_host_model.put(8'h10, 8'h05);
      @(posedge sys_clk);
      req <= 8'h40;
      tick(2);
      chk(drv | {clamp, 7'h00}, 8'h40);
      for (int j = 0; j < 3; j++) begin
         i_cfg_host_model.put(8'h0b, {6'h00, j[1:0]});
         tick(1);
         chk({6'h00, shift}, j[7:0]);
      end
      for (int s = 0; s < 2; s++) begin
         i_cfg_host_model.put(8'h0b, {5'h00, s[0], 2'b01});
         tick(2);
         n = 0;
         @(posedge sys_clk);
         start <= 1'b1;
         @(posedge sys_clk);
         start <= 1'b0;
         for (int i = 0; i < 12; i++) begin
            #1;
            n += (active === 1'b1);
            @(posedge sys_clk);
            start <= (i == 1);
         end
         chk(n[7:0], s ? 8'h08 : 8'h05);
      end
      for (int st = 0; st < 8; st++) begin
         i_cfg_host_model.put(8'h0f, st[7:0]);
         settle_wait();
         chk(n[7:0], SETTLE[7:0]);
         chk({5'h00, div_log2}, 8'h07 - st[7:0]);
      end
      i_cfg_host_model.put(8'h0f, 8'h13);
      settle_wait();
      @(posedge sys_clk);
      window <= 1'b1;
      tick(2);
      chk({7'h00, sw_hold}, 8'h01);
      i_cfg_host_model.put(8'h0f, 8'h03);
      tick(2);
      chk({7'h00, sw_hold}, 8'h00);
      @(posedge sys_clk);
      nrst <= 1'b0;
      window <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      rd_chk(8'h0d, 8'h80);
      rd_chk(8'h0f, 8'h00);
      wrap_up();
   end
endmodule : oled_drive_analog_ctrl_regs_tb
